// ===== scfg_config.sv
// configuration register, hysteresis alarm tracking and alert pin control
`default_nettype none
module scfg_config (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire scfg_pkg::scfg_access_s acc,
    input  wire scfg_pkg::scfg_sample_s smp,
    output logic [15:0]               rdata,
    output logic                      rdata_valid,
    output scfg_pkg::scfg_fields_s    cfg,
    output logic                      conv_enable,
    output scfg_pkg::scfg_flags_s     flags,
    output logic                      alert_out,
    output logic                      alert_oe
);
    import scfg_pkg::*;

    // hysteresis code to quarter degrees
    function automatic logic [calc_w-1:0] hyst_amount(input scfg_hyst_e h);
        unique case (h)
            hyst_none: hyst_amount = hyst_q_off;
            hyst_1p5:  hyst_amount = hyst_q_1p5;
            hyst_3p0:  hyst_amount = hyst_q_3p0;
            hyst_6p0:  hyst_amount = hyst_q_6p0;
        endcase
    endfunction

    // above-limit tracker: rises with no offset, falls only past limit minus hysteresis
    function automatic logic track_above(
        input logic                     above,
        input logic signed [temp_w-1:0] t,
        input logic signed [temp_w-1:0] lim,
        input logic [calc_w-1:0]        hy
    );
        logic signed [calc_w-1:0] te;
        logic signed [calc_w-1:0] le;
        logic signed [calc_w-1:0] fall;
        te   = calc_w'(t);
        le   = calc_w'(lim);
        fall = le - $signed(hy);
        if (te > le)
            track_above = 1'b1;
        else if (te < fall)
            track_above = 1'b0;
        else
            track_above = above;
    endfunction

    // state
    logic        above_upper;
    logic        above_lower;
    logic        above_crit;
    logic        event_latched;
    logic        cond_prev;

    // access decode
    wire         hit       = (acc.ptr == ptr_config);
    wire         cfg_wr    = acc.wr && hit;
    wire         any_lock  = cfg.critical_limit_lock | cfg.window_limit_lock;
    wire         clear_req = cfg_wr && acc.wdata[bit_clear];
    wire         powered   = !cfg.sensor_power_down;

    // next values of the fields; reserved and read-only bits never stored
    wire scfg_hyst_e next_hyst  = (cfg_wr && !any_lock) ?
                                  scfg_hyst_e'(acc.wdata[bit_hyst_hi:bit_hyst_lo]) :
                                  cfg.hysteresis_select;
    wire         next_pdn       = (cfg_wr && !any_lock) ?
                                  acc.wdata[bit_power_dn] : cfg.sensor_power_down;
    wire         next_clock     = cfg.critical_limit_lock |
                                  (cfg_wr & acc.wdata[bit_crit_lock]);
    wire         next_wlock     = cfg.window_limit_lock |
                                  (cfg_wr & acc.wdata[bit_win_lock]);
    wire         next_out_en    = (cfg_wr && !any_lock) ?
                                  acc.wdata[bit_out_en] : cfg.alert_output_enable;
    wire         next_crit_only = (cfg_wr && !cfg.window_limit_lock) ?
                                  acc.wdata[bit_crit_only] : cfg.alert_critical_only;
    wire         next_pol       = (cfg_wr && !any_lock) ?
                                  acc.wdata[bit_polarity] : cfg.alert_polarity;
    wire         next_mode      = (cfg_wr && !any_lock) ?
                                  acc.wdata[bit_mode] : cfg.alert_mode_select;

    // one hysteresis figure for all three limits
    wire [calc_w-1:0] hy = hyst_amount(cfg.hysteresis_select);
    wire         take = smp.done && powered;
    wire         next_above_upper = take ?
                                    track_above(above_upper, smp.temp, smp.upper, hy) :
                                    above_upper;
    wire         next_above_lower = take ?
                                    track_above(above_lower, smp.temp, smp.lower, hy) :
                                    above_lower;
    wire         next_above_crit  = take ?
                                    track_above(above_crit, smp.temp, smp.crit, hy) :
                                    above_crit;

    // alarm condition from the same trackers as the flags
    wire         window_cond = next_above_upper | !next_above_lower;
    wire         next_cond   = next_above_crit |
                               (!cfg.alert_critical_only & window_cond);
    // interrupt mode catches the rising edge of the condition; a new event beats a clear
    wire         new_event   = take && next_cond && !cond_prev;
    wire         next_latch  = !cfg.alert_mode_select ? 1'b0 :
                               new_event ? 1'b1 :
                               clear_req ? 1'b0 : event_latched;
    wire         next_cond_prev = take ? next_cond : cond_prev;
    wire         active_raw  = cfg.alert_mode_select ? next_latch : next_cond;
    wire         next_active = active_raw && cfg.alert_output_enable;
    // open drain: only the asserted low level, or the inactive low of high polarity, is driven
    wire         drive_low   = cfg.alert_polarity ? !next_active : next_active;
    wire         next_oe     = powered && drive_low;

    // readback word; reserved, clear and status positions assembled here
    wire [15:0]  cfg_word = {5'h00,
                             cfg.hysteresis_select,
                             cfg.sensor_power_down,
                             cfg.critical_limit_lock,
                             cfg.window_limit_lock,
                             1'b0,                                   // clear reads zero
                             powered & next_active,
                             cfg.alert_output_enable,
                             cfg.alert_critical_only,
                             cfg.alert_polarity,
                             cfg.alert_mode_select};

    // configuration fields; reserved bits have no storage at all
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // stored fields only: bits 10:6 and 3:0, nine bits in all
            cfg <= scfg_fields_s'({config_reset[bit_hyst_hi:bit_win_lock],
                                   config_reset[bit_out_en:bit_mode]});
        end else if (ce) begin
            cfg.hysteresis_select   <= next_hyst;
            cfg.sensor_power_down   <= next_pdn;
            cfg.critical_limit_lock <= next_clock;
            cfg.window_limit_lock   <= next_wlock;
            cfg.alert_output_enable <= next_out_en;
            cfg.alert_critical_only <= next_crit_only;
            cfg.alert_polarity      <= next_pol;
            cfg.alert_mode_select   <= next_mode;
        end
    end

    // limit trackers and alarm flags hold their state through power-down
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            above_upper <= 1'b0;
            above_lower <= 1'b1;
            above_crit  <= 1'b0;
            flags       <= '0;
        end else if (ce) begin
            above_upper <= next_above_upper;
            above_lower <= next_above_lower;
            above_crit  <= next_above_crit;
            flags.upper <= next_above_upper;
            flags.crit  <= next_above_crit;
            flags.lower <= !next_above_lower;
        end
    end

    // alert event latch and pin drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            event_latched <= 1'b0;
            cond_prev     <= 1'b0;
            alert_oe      <= 1'b0;
            alert_out     <= 1'b0;
            conv_enable   <= 1'b0;
        end else if (ce) begin
            event_latched <= next_latch;
            cond_prev     <= next_cond_prev;
            alert_oe      <= next_oe;
            alert_out     <= 1'b0;        // open drain only ever pulls low
            conv_enable   <= !next_pdn;
        end
    end

    // registered readback, zero when another register is addressed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata       <= 16'h0000;
            rdata_valid <= 1'b0;
        end else if (ce) begin
            rdata       <= (acc.rd && hit) ? cfg_word : 16'h0000;
            rdata_valid <= acc.rd && hit;
        end
    end
endmodule
`default_nettype wire

// ===== scfg_pkg.sv
// constants, field layout and carriers of the sensor configuration register
//Contract
//- One 16-bit configuration register sits at pointer address 01h and is readable and writable.
//- Bits 15:11 read as zero and the host writes them only as zero.
//- Bits 10:9 pick a hysteresis of 0, 1.5, 3.0 or 6.0 degrees for codes 00, 01, 10, 11.
//- The chosen hysteresis applies to the upper, lower and critical limits alike.
//- Hysteresis acts only on falling temperature; a rise trips as soon as it passes a limit.
//- A comparator alert stays on until the temperature falls below limit minus hysteresis.
//- The upper alarm flag (temperature bit 14) holds until below upper limit minus hysteresis.
//- The same hysteresis thresholds drive the alert pin as drive the alarm flags.
//- While either lock is set, writes to the hysteresis field are ignored.
//- Bit 8 at 0 keeps conversions running, at 1 switches the sensor off.
//- Powered down, no conversion is done, no data is updated and no alert is raised.
//- Powered down, the alert pin is released and driven in neither state.
//- While either lock is set, writes to the power-down bit are ignored.
//- Once written to 1, a lock bit holds until power-on reset.
//- The alert mode bit selects comparator operation at 0 and interrupt operation at 1.
`default_nettype none
package scfg_pkg;
    localparam logic [7:0]  ptr_config      = 8'h01;
    localparam logic [15:0] config_reset    = 16'h0000;
    localparam int          temp_w          = 11;   // quarter-degree two's complement
    localparam int          calc_w          = 13;   // headroom for limit minus hysteresis
    // hysteresis in quarter degrees: 0, 1.5, 3.0, 6.0 degrees
    localparam logic [calc_w-1:0] hyst_q_off = 13'h0000;
    localparam logic [calc_w-1:0] hyst_q_1p5 = 13'h0006;
    localparam logic [calc_w-1:0] hyst_q_3p0 = 13'h000c;
    localparam logic [calc_w-1:0] hyst_q_6p0 = 13'h0018;
    // bit positions inside the configuration word
    localparam int bit_hyst_hi   = 10;
    localparam int bit_hyst_lo   = 9;
    localparam int bit_power_dn  = 8;
    localparam int bit_crit_lock = 7;
    localparam int bit_win_lock  = 6;
    localparam int bit_clear     = 5;
    localparam int bit_asserted  = 4;
    localparam int bit_out_en    = 3;
    localparam int bit_crit_only = 2;
    localparam int bit_polarity  = 1;
    localparam int bit_mode      = 0;

    typedef enum logic [1:0] {
        hyst_none,
        hyst_1p5,
        hyst_3p0,
        hyst_6p0
    } scfg_hyst_e;

    // stored, writable fields of the configuration register
    typedef struct packed {
        scfg_hyst_e hysteresis_select;
        logic       sensor_power_down;
        logic       critical_limit_lock;
        logic       window_limit_lock;
        logic       alert_output_enable;
        logic       alert_critical_only;
        logic       alert_polarity;
        logic       alert_mode_select;
    } scfg_fields_s;

    // register access from the serial engine
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  ptr;
        logic [15:0] wdata;
    } scfg_access_s;

    // conversion result and alarm limits, all quarter degrees
    typedef struct packed {
        logic                      done;
        logic signed [temp_w-1:0]  temp;
        logic signed [temp_w-1:0]  upper;
        logic signed [temp_w-1:0]  lower;
        logic signed [temp_w-1:0]  crit;
    } scfg_sample_s;

    // alarm flags as they sit in temperature register bits 15:13
    typedef struct packed {
        logic crit;
        logic upper;
        logic lower;
    } scfg_flags_s;
endpackage
`default_nettype wire

// ===== scfg_config_monitor.sv
// port-level assertion checker for the sensor configuration register
`default_nettype none
module scfg_config_monitor
    import scfg_pkg::*;
(
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire logic                   ce,
    input wire scfg_pkg::scfg_access_s acc,
    input wire scfg_pkg::scfg_sample_s smp,
    input wire logic [15:0]            rdata,
    input wire logic                   rdata_valid,
    input wire scfg_pkg::scfg_fields_s cfg,
    input wire logic                   conv_enable,
    input wire scfg_pkg::scfg_flags_s  flags,
    input wire logic                   alert_out,
    input wire logic                   alert_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // decoded access and lock state
    wire hit  = ce && acc.ptr == ptr_config;
    wire lock = cfg.critical_limit_lock | cfg.window_limit_lock;
    sequence s_read;
        hit && acc.rd;
    endsequence
    sequence s_free_write;
        hit && acc.wr && !lock;
    endsequence
    rd_answer_a: assert property (s_read |=> rdata_valid) else $error("read not answered");
    rsvd_zero_a: assert property (rdata_valid |-> rdata[15:11] == 5'h00 && !rdata[5])
        else $error("reserved bits read nonzero");
    wr_store_a: assert property (s_free_write |=>
        cfg.hysteresis_select == $past(acc.wdata[10:9]) && conv_enable == !$past(acc.wdata[8]))
        else $error("write not stored");
    lock_freeze_a: assert property (lock |=> $stable(cfg.hysteresis_select)
        && $stable(cfg.sensor_power_down)) else $error("locked field changed");
    lock_keep_a: assert property (lock |=> lock) else $error("lock bit dropped");
    pdn_release_a: assert property (cfg.sensor_power_down && $past(cfg.sensor_power_down)
        |-> !alert_oe) else $error("alert driven while powered down");
    flag_hold_a: assert property (cfg.sensor_power_down |=> $stable(flags))
        else $error("flags moved while powered down");
    rise_trip_a: assert property (ce && smp.done && !cfg.sensor_power_down
        && smp.temp > smp.upper |=> flags.upper) else $error("rise did not trip");
endmodule
bind scfg_config scfg_config_monitor mon (.mclk(mclk), .rst(rst), .ce(ce), .acc(acc), .smp(smp),
    .rdata(rdata), .rdata_valid(rdata_valid), .cfg(cfg), .conv_enable(conv_enable),
    .flags(flags), .alert_out(alert_out), .alert_oe(alert_oe));
`default_nettype wire

// ===== scfg_host.sv
// serial engine model issuing one-cycle register accesses
`default_nettype none
module scfg_host
    import scfg_pkg::*;
(
    input  wire logic                  mclk,
    output var scfg_pkg::scfg_access_s acc
);
    timeunit 1ns;
    timeprecision 100ps;
    initial acc = '0;
    // released fields are scrambled so stale values never pass for a live request
    task automatic wr(input logic [15:0] d);
        @(posedge mclk);
        acc <= '{wr: 1'b1, rd: 1'b0, ptr: ptr_config, wdata: d & 16'h07ff};
        @(posedge mclk);
        acc <= '{wr: 1'b0, rd: 1'b0, ptr: ~ptr_config, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] p);
        @(posedge mclk);
        acc <= '{wr: 1'b0, rd: 1'b1, ptr: p, wdata: 16'h5a5a};
        @(posedge mclk);
        acc <= '{wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: 16'ha5a5};
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the sensor configuration register
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import scfg_pkg::*;
    logic         mclk = 1'b0;
    logic         rst  = 1'b1;
    logic         ce   = 1'b1;
    scfg_access_s acc;
    scfg_sample_s smp  = '0;
    scfg_fields_s cfg;
    scfg_flags_s  flags;
    logic [15:0]  rdata;
    logic [15:0]  word;
    logic         rdata_valid;
    logic         conv_enable;
    logic         alert_out;
    logic         alert_oe;
    int           n_errors   = 0;
    int           n_compared = 0;
    int           cycles     = 0;
    int           hq;
    scfg_host host (.mclk(mclk), .acc(acc));
    scfg_config dut (.mclk(mclk), .rst(rst), .ce(ce), .acc(acc), .smp(smp), .rdata(rdata),
        .rdata_valid(rdata_valid), .cfg(cfg), .conv_enable(conv_enable), .flags(flags),
        .alert_out(alert_out), .alert_oe(alert_oe));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] p, output logic [15:0] r);
        host.rd(p);
        #1;
        check({15'h0000, rdata_valid}, {15'h0000, p == ptr_config});
        r = rdata;
    endtask
    // upper and critical limits share 85 degrees so both trackers move together
    task automatic sample(input int t, input logic [2:0] f);
        @(posedge mclk);
        smp <= '{done: 1'b1, temp: 11'(t), upper: 11'sd340, lower: -11'sd100, crit: 11'sd340};
        @(posedge mclk);
        smp.done <= 1'b0;
        smp.temp <= ~smp.temp;
        #1;
        check({13'h0000, flags}, {13'h0000, f});
    endtask
    task automatic wrap_up();
        $display("errors %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, far above the fewer than one hundred cycles the sequence needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h01, word);
        check(word, config_reset);
        rd(8'h02, word);
        // every hysteresis code: hold at the boundary, clear one step below
        for (int h = 0; h < 4; h++) begin
            hq = (h == 0) ? 0 : 3 << h;
            host.wr({5'h00, 2'(h), 9'h008});
            sample(341, 3'b110);
            check({15'h0000, alert_oe}, 16'h0001);
            sample(340 - hq, 3'b110);
            sample(339 - hq, 3'b000);
            check({15'h0000, alert_oe}, 16'h0000);
        end
        sample(341, 3'b110);
        rd(8'h01, word);
        check(word, 16'h0618);
        host.wr(16'h0708);
        repeat (2) @(posedge mclk);
        #1;
        check({13'h0000, alert_out, conv_enable, alert_oe}, 16'h0000);
        sample(200, 3'b110);
        rd(8'h01, word);
        check(word, 16'h0708);
        host.wr(16'h0608);
        repeat (2) @(posedge mclk);
        #1;
        check({13'h0000, alert_out, conv_enable, alert_oe}, 16'h0003);
        host.wr(16'h0248);
        host.wr(16'h0101);
        rd(8'h01, word);
        check(word, 16'h0258);
        host.wr(16'h0000);
        rd(8'h01, word);
        check(word, 16'h0258);
        // clock enable low: an addressed read is not answered
        @(posedge mclk);
        ce <= 1'b0;
        host.rd(8'h01);
        #1;
        check({15'h0000, rdata_valid}, 16'h0000);
        @(posedge mclk);
        ce <= 1'b1;
        // a second reset releases the window lock and every field
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h01, word);
        check(word, config_reset);
        check({13'h0000, flags}, 16'h0000);
        // interrupt mode: the event outlives its cause until cleared
        host.wr(16'h0009);
        sample(341, 3'b110);
        sample(339, 3'b000);
        check({15'h0000, alert_oe}, 16'h0001);
        host.wr(16'h0029);
        #1;
        check({15'h0000, alert_oe}, 16'h0000);
        // high polarity: the pin is pulled low while the alert is idle
        host.wr(16'h000a);
        @(posedge mclk);
        #1;
        check({15'h0000, alert_oe}, 16'h0001);
        wrap_up();
    end
endmodule
`default_nettype wire
